/* File: src/csq_sqrt.sv */
// Pipelined hyperbolic CORDIC square-root unit
// Overview of operation
// - The root is formed by a fully parallel chain of hyperbolic vectoring stages.
// - The start vector is X = w + 0.25 and Y = w - 0.25 from normalized w.
// - A negative input is made non-negative and its sign travels to the end.
// - Every input converges except the most negative code, which is undefined.
// - A zero input raises a flag that travels along and forces the result to 0.
// - The magnitude is shifted left until it lies in [0.25, 1).
// - The left shift is kept even and half of it goes to the correction stage.
// - Each stage rotates by a smaller angle, or an equal one at a repeated step, steering Y toward zero.
// - Correction scales by 2 to the minus (half shift + BASE_RSH) and applies the sign.
// - The number of rotation stages is a parameter of at least 1.
// - A parameter sets the register stages after each rotation.
// - Latency is 7 + I + I mod 2 + all rotation latencies, I = WIDTH - BIN_PT.
`timescale 1ns/10ps
module csq_sqrt #(
  parameter int          WIDTH    = csq_pkg::WIDTH_DEF,
  parameter int          BIN_PT   = csq_pkg::BIN_PT_DEF,
  parameter int          N_PE     = csq_pkg::N_PE_DEF,
  parameter int          PE_LAT   = csq_pkg::PE_LAT_DEF,
  parameter logic [16:0] INV_GAIN = csq_pkg::INV_GAIN_DEF
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    valid_i,
  input  wire logic signed [WIDTH-1:0] x_i,
  output logic                         valid_o,
  output logic signed [WIDTH-1:0]      sqrt_o
);

  // ----------------------------------------------------------------
  // Derived sizes
  // ----------------------------------------------------------------
  localparam int INT_BITS = WIDTH - BIN_PT;
  localparam int EXTRA = INT_BITS + INT_BITS % 2;
  localparam int NPE = (N_PE < 1) ? 1 : N_PE;
  localparam int LAT_TOTAL = csq_pkg::FIXED_LAT + EXTRA + NPE * PE_LAT;
  localparam int EXP = WIDTH - 1 - BIN_PT;
  localparam int EXP2 = EXP + EXP % 2;
  localparam int PRE = WIDTH - BIN_PT - EXP2;
  localparam int BASE_RSH = EXP2 / 2 + PRE;
  localparam int SHW = $clog2(WIDTH + 1);
  localparam int IW = WIDTH + csq_pkg::HEADROOM;
  localparam int SIDEW = 3 + SHW;
  localparam int GW = IW + csq_pkg::GAIN_FRAC + 1;
  localparam logic signed [IW-1:0] QUARTER = IW'(1) << (WIDTH - 2);
  localparam logic signed [WIDTH-1:0] MOST_NEG = {1'b1, {(WIDTH-1){1'b0}}};

  function automatic logic [SHW-1:0] lead_zeros(input logic [WIDTH-1:0] v);
    logic [SHW-1:0] n;
    logic           found;
    n = '0;
    found = 1'b0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (!found) begin
        if (v[i]) begin
          found = 1'b1;
        end else begin
          n = n + 1'b1;
        end
      end
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Input register and delay line
  // ----------------------------------------------------------------
  logic signed [WIDTH-1:0] dly_x [0:EXTRA];
  logic                    dly_v [0:EXTRA];

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      for (int k = 0; k <= EXTRA; k++) begin
        dly_x[k] <= '0;
        dly_v[k] <= 1'b0;
      end
    end else begin
      dly_x[0] <= x_i;
      dly_v[0] <= valid_i;
      for (int k = 1; k <= EXTRA; k++) begin
        dly_x[k] <= dly_x[k-1];
        dly_v[k] <= dly_v[k-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sign and zero handling
  // ----------------------------------------------------------------
  logic signed [WIDTH-1:0] in_w;
  logic [WIDTH-1:0]        abs_w;
  logic [WIDTH-1:0]        frac;
  logic                    s2_neg;
  logic                    s2_zero;
  logic                    s2_v;

  assign in_w = dly_x[EXTRA];
  assign abs_w = in_w[WIDTH-1] ? WIDTH'(-in_w) : WIDTH'(in_w);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      frac <= '0;
      s2_neg <= 1'b0;
      s2_zero <= 1'b0;
      s2_v <= 1'b0;
    end else begin
      frac <= WIDTH'(abs_w << PRE);
      s2_neg <= in_w[WIDTH-1];
      s2_zero <= (in_w == '0);
      s2_v <= dly_v[EXTRA];
    end
  end

  // ----------------------------------------------------------------
  // Even-shift normalization
  // ----------------------------------------------------------------
  logic [SHW-1:0]   lz;
  logic [SHW-1:0]   even_sh;
  logic [WIDTH-1:0] norm;
  logic [SHW-1:0]   half_sh;
  logic             s3_neg;
  logic             s3_zero;
  logic             s3_v;

  assign lz = lead_zeros(frac);
  assign even_sh = {lz[SHW-1:1], 1'b0};

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      norm <= '0;
      half_sh <= '0;
      s3_neg <= 1'b0;
      s3_zero <= 1'b0;
      s3_v <= 1'b0;
    end else begin
      norm <= frac << even_sh;
      half_sh <= lz >> 1;
      s3_neg <= s2_neg;
      s3_zero <= s2_zero;
      s3_v <= s2_v;
    end
  end

  // ----------------------------------------------------------------
  // Start vector and rotation chain
  // ----------------------------------------------------------------
  logic signed [IW-1:0] rx [0:NPE];
  logic signed [IW-1:0] ry [0:NPE];
  logic [SIDEW-1:0]     rs [0:NPE];

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rx[0] <= '0;
      ry[0] <= '0;
      rs[0] <= '0;
    end else begin
      rx[0] <= $signed({3'h0, norm}) + QUARTER;
      ry[0] <= $signed({3'h0, norm}) - QUARTER;
      rs[0] <= {s3_v, s3_neg, s3_zero, half_sh};
    end
  end

  generate
    for (genvar g = 0; g < NPE; g++) begin : g_pe
      csq_hyp_stage #(
        .IW    (IW),
        .SIDEW (SIDEW),
        .SHIFT (csq_pkg::hyp_shift(g)),
        .LAT   (PE_LAT)
      ) u_stage (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .x_i       (rx[g]),
        .y_i       (ry[g]),
        .side_i    (rs[g]),
        .x_o       (rx[g+1]),
        .y_o       (ry[g+1]),
        .side_o    (rs[g+1])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Gain removal, scaling and sign
  // ----------------------------------------------------------------
  logic signed [GW-1:0]    prod;
  logic [WIDTH:0]          root;
  logic [WIDTH:0]          scaled;
  logic [SIDEW-1:0]        s5_side;
  logic [SIDEW-1:0]        s6_side;
  logic                    out_zero;

  assign prod = rx[NPE] * $signed({1'b0, INV_GAIN});

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      root <= '0;
      s5_side <= '0;
    end else begin
      root <= prod[csq_pkg::GAIN_FRAC +: WIDTH + 1];
      s5_side <= rs[NPE];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      scaled <= '0;
      s6_side <= '0;
    end else begin
      scaled <= root >> (BASE_RSH + int'(s5_side[SHW-1:0]));
      s6_side <= s5_side;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sqrt_o <= '0;
      valid_o <= 1'b0;
      out_zero <= 1'b0;
    end else begin
      valid_o <= s6_side[SHW+2];
      out_zero <= s6_side[SHW];
      if (s6_side[SHW]) begin
        sqrt_o <= '0;
      end else if (s6_side[SHW+1]) begin
        sqrt_o <= -$signed(scaled[WIDTH-1:0]);
      end else begin
        sqrt_o <= $signed(scaled[WIDTH-1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] since_rst;
  logic        filled;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      since_rst <= '0;
    end else if (!filled) begin
      since_rst <= since_rst + 16'h0001;
    end
  end
  assign filled = (int'(since_rst) > LAT_TOTAL);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  chk_valid_latency: assert property (filled |->
      valid_o == $past(valid_i, LAT_TOTAL))
    else $error("valid did not emerge after the total latency");

  chk_zero_result: assert property ((filled &&
      $past(valid_i && x_i == '0, LAT_TOTAL)) |-> sqrt_o == '0)
    else $error("zero input gave a non-zero result");

  chk_neg_sign: assert property ((filled &&
      $past(x_i < 0 && x_i != MOST_NEG, LAT_TOTAL)) |-> sqrt_o <= 0)
    else $error("negative input gave a positive result");

  chk_pos_sign: assert property ((filled &&
      $past(x_i >= 0, LAT_TOTAL)) |-> sqrt_o >= 0)
    else $error("non-negative input gave a negative result");

  chk_zero_pairs: assert property (filled |->
      out_zero == $past(x_i == '0, LAT_TOTAL))
    else $error("zero flag lost its pairing with the data");

  chk_shift_even: assert property (s3_v |->
      (norm >> {half_sh, 1'b0}) == $past(frac, 1))
    else $error("normalizing shift was not even");

  chk_norm_range: assert property ((s3_v && !s3_zero) |->
      norm[WIDTH-1:WIDTH-2] != 2'b00)
    else $error("normalized value fell below one quarter");

  chk_init_vector: assert property (rs[0][SHW+2] |->
      rx[0] - ry[0] == QUARTER + QUARTER && rx[0] == $signed({3'h0,
      $past(norm, 1)}) + QUARTER)
    else $error("start vector is not w plus and minus one quarter");

endmodule

/* File: pkg/csq_pkg.sv */
// Shared constants and helpers for the square-root pipeline
package csq_pkg;

  // ----------------------------------------------------------------
  // Pipeline timing
  // ----------------------------------------------------------------
  localparam int FIXED_LAT = 7;
  localparam int PE_LAT_DEF = 1;
  localparam int N_PE_DEF = 8;
  localparam int WIDTH_DEF = 16;
  localparam int BIN_PT_DEF = 14;
  localparam int HEADROOM = 3;

  // ----------------------------------------------------------------
  // Gain compensation, unsigned with GAIN_FRAC fraction bits
  // ----------------------------------------------------------------
  localparam int GAIN_FRAC = 16;
  localparam logic [16:0] INV_GAIN_DEF = 17'h1351D;
  localparam int REPEAT_FIRST = 4;

  // ----------------------------------------------------------------
  // Shift of rotation k, with the classic repeated steps 4, 13, 40
  // ----------------------------------------------------------------
  function automatic int hyp_shift(input int k);
    int i;
    int rep;
    bit done;
    i = 1;
    rep = REPEAT_FIRST;
    done = 1'b0;
    for (int n = 0; n < k; n++) begin
      if (i == rep && !done) begin
        done = 1'b1;
      end else begin
        if (i == rep) begin
          rep = 3 * rep + 1;
          done = 1'b0;
        end
        i++;
      end
    end
    return i;
  endfunction

endpackage

/* File: src/csq_hyp_stage.sv */
// One hyperbolic vectoring rotation with its pipeline registers
`timescale 1ns/10ps
module csq_hyp_stage #(
  parameter int IW    = 19,
  parameter int SIDEW = 8,
  parameter int SHIFT = 1,
  parameter int LAT   = 1
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  input  wire logic signed [IW-1:0] x_i,
  input  wire logic signed [IW-1:0] y_i,
  input  wire logic [SIDEW-1:0]     side_i,
  output logic signed [IW-1:0]      x_o,
  output logic signed [IW-1:0]      y_o,
  output logic [SIDEW-1:0]          side_o
);

  // ----------------------------------------------------------------
  // Rotation toward y = 0
  // ----------------------------------------------------------------
  logic signed [IW-1:0] next_x;
  logic signed [IW-1:0] next_y;

  always_comb begin
    if (y_i < 0) begin
      next_x = x_i + (y_i >>> SHIFT);
      next_y = y_i + (x_i >>> SHIFT);
    end else begin
      next_x = x_i - (y_i >>> SHIFT);
      next_y = y_i - (x_i >>> SHIFT);
    end
  end

  // ----------------------------------------------------------------
  // Pipeline registers after the rotation
  // ----------------------------------------------------------------
  generate
    if (LAT == 0) begin : g_comb
      assign x_o = next_x;
      assign y_o = next_y;
      assign side_o = side_i;
    end else begin : g_pipe
      logic signed [IW-1:0] px [0:LAT-1];
      logic signed [IW-1:0] py [0:LAT-1];
      logic [SIDEW-1:0]     ps [0:LAT-1];
      always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
          for (int k = 0; k < LAT; k++) begin
            px[k] <= '0;
            py[k] <= '0;
            ps[k] <= '0;
          end
        end else begin
          px[0] <= next_x;
          py[0] <= next_y;
          ps[0] <= side_i;
          for (int k = 1; k < LAT; k++) begin
            px[k] <= px[k-1];
            py[k] <= py[k-1];
            ps[k] <= ps[k-1];
          end
        end
      end
      assign x_o = px[LAT-1];
      assign y_o = py[LAT-1];
      assign side_o = ps[LAT-1];
    end
  endgenerate

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  chk_x_positive: assert property ((x_i > 0 && x_i > y_i && x_i > -y_i)
      |-> next_x > 0)
    else $error("rotation drove x non-positive");

endmodule

/* File: dv/csq_far_end.sv */
// Feeder and result logger facing the square-root pipeline
`timescale 1ns/10ps
module csq_far_end #(
  parameter int WIDTH = 16
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    valid_i,
  input  wire logic signed [WIDTH-1:0] sqrt_i,
  output logic                         valid_o,
  output logic signed [WIDTH-1:0]      x_o,
  output int                           cyc_o
);
  logic [WIDTH:0] log_q [0:4095];

  initial begin
    valid_o = 1'b0;
    x_o = '0;
    cyc_o = 0;
  end

  // ----------------------------------------------------------------
  // Edge counter and settled result log
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    cyc_o <= cyc_o + 1;
  end

  always @(negedge ref_clk_i) begin
    log_q[cyc_o[11:0]] <= {valid_i, sqrt_i};
  end

  // ----------------------------------------------------------------
  // Sample source, one word per cycle at the falling edge
  // ----------------------------------------------------------------
  task automatic send(input logic signed [WIDTH-1:0] x, input logic v,
                      output int cap);
    @(negedge ref_clk_i);
    valid_o = v;
    x_o = x;
    cap = cyc_o;
  endtask

  // Idle slot: data keeps toggling, no stale value
  task automatic idle();
    @(negedge ref_clk_i);
    valid_o = 1'b0;
    x_o = ~x_o;
  endtask
endmodule

/* File: dv/test_csq_sqrt.sv */
// Self-checking testbench for the square-root pipeline
`timescale 1ns/10ps
module test_csq_sqrt;
  localparam int WIDTH  = 16;
  localparam int BIN_PT = 14;
  localparam int N_PE   = 8;
  localparam int PE_LAT = 1;
  localparam int I_BITS = WIDTH - BIN_PT;
  localparam int LAT    = 7 + I_BITS + I_BITS % 2 + N_PE * PE_LAT;
  localparam int TOL    = 6;

  logic                    ref_clk_i;
  logic                    reset_i;
  logic                    valid_i;
  logic signed [WIDTH-1:0] x_i;
  logic                    valid_o;
  logic signed [WIDTH-1:0] sqrt_o;
  int                      cyc;
  int                      err_count;
  int                      n_checks;

  csq_sqrt #(.WIDTH(WIDTH), .BIN_PT(BIN_PT), .N_PE(N_PE), .PE_LAT(PE_LAT))
  u_dut (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .valid_i   (valid_i),
    .x_i       (x_i),
    .valid_o   (valid_o),
    .sqrt_o    (sqrt_o)
  );

  csq_far_end #(.WIDTH(WIDTH)) u_far (
    .ref_clk_i (ref_clk_i),
    .valid_i   (valid_o),
    .sqrt_i    (sqrt_o),
    .valid_o   (valid_i),
    .x_o       (x_i),
    .cyc_o     (cyc)
  );

  // ----------------------------------------------------------------
  // Clock, comparison and verdict
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic signed [31:0] seen,
                       input logic signed [31:0] exp, input int tol);
    int d;
    n_checks++;
    d = seen - exp;
    if ((^seen) === 1'bx || d > tol || d < -tol) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic int exp_root(input logic signed [WIDTH-1:0] x);
    real r;
    r = $sqrt((x < 0 ? -x : x) / real'(1 << BIN_PT)) * (1 << BIN_PT);
    return x < 0 ? -$rtoi(r + 0.5) : $rtoi(r + 0.5);
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_state();
    @(negedge ref_clk_i);
    check(valid_o, 0, 0);
    check(sqrt_o, 0, 0);
  endtask

  task automatic t_latency();
    int cap;
    int n;
    u_far.send(16'sh4000, 1'b1, cap);
    u_far.idle();
    n = 1;
    while (valid_o !== 1'b1 && n < 40) begin
      u_far.idle();
      n++;
    end
    if (n >= 40) begin
      err_count++;
      test_done();
    end else begin
      check(cyc - cap, LAT, 0);
      check(sqrt_o, 16'sh4000, TOL);
    end
  endtask

  task automatic t_stream();
    logic signed [WIDTH-1:0] xs [10] = '{16'sh0000, 16'sh1000, 16'sh0001,
      16'sh0002, 16'sh4000, 16'sh1000, 16'sh7FFF, 16'shC000, 16'shFFFF,
      16'sh8000};
    logic vs [10] = '{1, 1, 1, 1, 1, 0, 1, 1, 1, 1};
    int caps [10];
    logic [WIDTH:0] r;
    for (int k = 0; k < 10; k++) begin
      u_far.send(xs[k], vs[k], caps[k]);
    end
    repeat (LAT + 3) u_far.idle();
    for (int k = 0; k < 10; k++) begin
      r = u_far.log_q[(caps[k] + LAT) % 4096];
      check(r[WIDTH], vs[k], 0);
      if (vs[k] && xs[k] != 16'sh8000) begin
        check($signed(r[WIDTH-1:0]), exp_root(xs[k]),
              xs[k] == 0 ? 0 : TOL);
      end
    end
  endtask

  task automatic t_flush();
    int cap;
    for (int k = 0; k < 4; k++) begin
      u_far.send(16'sh2000, 1'b1, cap);
    end
    u_far.idle();
    reset_i = 1'b1;
    cap = cyc + 1;
    @(negedge ref_clk_i);
    reset_i = 1'b0;
    repeat (LAT + 3) u_far.idle();
    for (int k = 0; k <= LAT + 2; k++) begin
      check(u_far.log_q[(cap + k) % 4096][WIDTH], 0, 0);
    end
  endtask

  initial begin
    err_count = 0;
    n_checks = 0;
    reset_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    reset_i = 1'b0;
    t_reset_state();
    t_latency();
    t_stream();
    t_flush();
    t_stream();
    test_done();
  end
endmodule
